// ### rtl/pwr_clk_pkg.sv
// Package: constants and types of the power and clock mode control block
// Operation
// - After reset the CPU runs from the slow oscillator and the fast oscillator is off.
// - After reset the oscillator regulator level bit is 0, the low 1.3 V setting.
// - After reset booster, both boost selects and the supply detector are all 0.
// - With the RC slow oscillator option and fast oscillator on, logic supply is held high.
`default_nettype none

package pwr_clk_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int CTRL_WIDTH = 8;

    // Control bits, CPU clock select in bit 0 (1 selects the fast clock)
    typedef struct packed {
        logic internal_logic_supply;
        logic supply_detector_enable;
        logic adc_boost_mode_select;
        logic osc_boost_mode_select;
        logic booster_enable;
        logic osc_regulator_level;
        logic fast_osc_enable;
        logic cpu_clock_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = ctrl_t'(8'h00);

    // Status field positions
    localparam int STAT_CLK_SRC_BIT = 0;
    localparam int STAT_LOGIC_HIGH_BIT = 1;
    localparam int STAT_RC_OPT_BIT = 2;
    localparam int STAT_PENDING_BIT = 3;

    // Strap capture: the two sync flops hold reset zeros until the second edge
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;

    // ****************************************************************
    // Module state
    // ****************************************************************
    typedef struct packed {
        ctrl_t ctrl;
        logic sel_active;
        logic slow_s1;
        logic slow_s2;
        logic fast_s1;
        logic fast_s2;
        logic clk_out;
        logic rc_s1;
        logic rc_s2;
        logic rc_opt;
        logic [1:0] strap_cnt;
        logic [31:0] prdata;
    } state_t;

    localparam state_t STATE_RESET = '{
        ctrl: CTRL_RESET, sel_active: 1'b0, slow_s1: 1'b0, slow_s2: 1'b0,
        fast_s1: 1'b0, fast_s2: 1'b0, clk_out: 1'b0, rc_s1: 1'b0, rc_s2: 1'b0,
        rc_opt: 1'b0, strap_cnt: 2'h0, prdata: 32'h0000_0000
    };

endpackage

`default_nettype wire

// ### rtl/power_clock_mode_control.sv
// Module: APB control of clock source, oscillator, regulator and booster modes
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`default_nettype none

module power_clock_mode_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator clocks and mask option strap, all asynchronous
    input wire logic slow_oscillator,
    input wire logic fast_oscillator,
    input wire logic rc_slow_osc_option,
    // Controls to the analog blocks
    output var pwr_clk_pkg::ctrl_t ctrl,
    output logic logic_supply_high,
    output logic cpu_clock
);

    // ****************************************************************
    // State
    // ****************************************************************
    pwr_clk_pkg::state_t st_r;
    pwr_clk_pkg::state_t st_nxt;
    logic wr_ctrl;
    logic logic_high;

    // Address decode for the error answer; the read mux decodes with its own case
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == pwr_clk_pkg::CTRL_OFFSET) || (a == pwr_clk_pkg::STATUS_OFFSET);
    endfunction

    // Write lands only at the access edge, so setup never changes the controls
    assign wr_ctrl = psel && penable && pwrite && (paddr == pwr_clk_pkg::CTRL_OFFSET);

    // Logic supply forced high when the RC slow option runs with the fast oscillator
    assign logic_high = (st_r.rc_opt && st_r.ctrl.fast_osc_enable)
        || st_r.ctrl.internal_logic_supply;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        // Two flops on every asynchronous input
        st_nxt.slow_s1 = slow_oscillator;
        st_nxt.slow_s2 = st_r.slow_s1;
        st_nxt.fast_s1 = fast_oscillator;
        st_nxt.fast_s2 = st_r.fast_s1;
        st_nxt.rc_s1 = rc_slow_osc_option;
        st_nxt.rc_s2 = st_r.rc_s1;
        // Strap caught once after reset release; mask options never change live.
        // Capture waits until the sync pair holds the pin, not its reset zeros.
        if (st_r.strap_cnt != pwr_clk_pkg::STRAP_DONE) begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
        end
        if (st_r.strap_cnt == pwr_clk_pkg::STRAP_SETTLE) begin
            st_nxt.rc_opt = st_r.rc_s2;
        end
        // Software writes land whole; ordering is left to software
        if (wr_ctrl) begin
            st_nxt.ctrl = pwr_clk_pkg::ctrl_t'(pwdata[pwr_clk_pkg::CTRL_WIDTH-1:0]);
        end
        // Source follows the select only with both clocks low, so no runt pulse
        if (!st_r.slow_s2 && !st_r.fast_s2) begin
            st_nxt.sel_active = st_r.ctrl.cpu_clock_select;
        end
        // Mux output uses the source that was active when this level was taken
        st_nxt.clk_out = st_r.sel_active ? st_r.fast_s2 : st_r.slow_s2;
        // Read data captured in the setup phase, stable through access
        if (psel && !penable) begin
            case (paddr)
                pwr_clk_pkg::CTRL_OFFSET: begin
                    st_nxt.prdata = {24'h00_0000, st_r.ctrl};
                end
                pwr_clk_pkg::STATUS_OFFSET: begin
                    st_nxt.prdata = 32'h0000_0000;
                    st_nxt.prdata[pwr_clk_pkg::STAT_CLK_SRC_BIT] = st_r.sel_active;
                    st_nxt.prdata[pwr_clk_pkg::STAT_LOGIC_HIGH_BIT] = logic_high;
                    st_nxt.prdata[pwr_clk_pkg::STAT_RC_OPT_BIT] = st_r.rc_opt;
                    st_nxt.prdata[pwr_clk_pkg::STAT_PENDING_BIT] =
                        st_r.sel_active != st_r.ctrl.cpu_clock_select;
                end
                default: begin
                    st_nxt.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Synchronous reset loads the documented initial settings
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r <= pwr_clk_pkg::STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Zero wait state slave; error only for an unmapped access phase
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = st_r.prdata;
    assign ctrl = st_r.ctrl;
    assign logic_supply_high = logic_high;
    assign cpu_clock = st_r.clk_out;

    // ****************************************************************
    // Checks
    // ****************************************************************
    reset_clock_a: assert property (
        @(posedge clk) !reset_n |=> !ctrl.cpu_clock_select && !ctrl.fast_osc_enable
            && !st_r.sel_active)
        else $error("clock controls not cleared by reset");

    reset_regulator_a: assert property (
        @(posedge clk) !reset_n |=> !ctrl.osc_regulator_level)
        else $error("regulator level not low after reset");

    reset_booster_a: assert property (
        @(posedge clk) !reset_n |=> !ctrl.booster_enable && !ctrl.osc_boost_mode_select
            && !ctrl.adc_boost_mode_select && !ctrl.supply_detector_enable)
        else $error("booster or detector not off after reset");

    logic_fixed_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        st_r.rc_opt && ctrl.fast_osc_enable |-> logic_supply_high)
        else $error("logic supply not held high with RC option");

    switch_low_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $changed(st_r.sel_active) |-> $past(!st_r.slow_s2 && !st_r.fast_s2))
        else $error("clock source changed while a clock was high");

    no_runt_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $changed(st_r.sel_active) |-> !cpu_clock)
        else $error("clock output high right after a source change");

    // Strap must not move once captured, or the logic supply could drop live
    strap_hold_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        st_r.strap_cnt == pwr_clk_pkg::STRAP_DONE |=> $stable(st_r.rc_opt))
        else $error("strap value changed after capture");

    supply_follow_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ctrl.internal_logic_supply |-> logic_supply_high)
        else $error("logic supply low although software raised it");

    // Read data of the control word must match the stored bits in the access phase
    ctrl_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && !pwrite && paddr == pwr_clk_pkg::CTRL_OFFSET
            |-> prdata == {24'h00_0000, ctrl})
        else $error("control read data wrong");

    status_ro_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && pwrite && paddr == pwr_clk_pkg::STATUS_OFFSET |=> $stable(ctrl))
        else $error("status write changed the controls");

    unmapped_err_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && paddr != pwr_clk_pkg::CTRL_OFFSET
            && paddr != pwr_clk_pkg::STATUS_OFFSET |-> pslverr)
        else $error("unmapped access without error");

    mapped_ok_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && (paddr == pwr_clk_pkg::CTRL_OFFSET
            || paddr == pwr_clk_pkg::STATUS_OFFSET) |-> !pslverr)
        else $error("mapped access answered with error");

    ctrl_write_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        wr_ctrl |=> ctrl == $past(pwdata[7:0]))
        else $error("control write not stored");

endmodule

`default_nettype wire

// ### verification/tb_top.sv
// Testbench: register sequences for the power and clock mode control block
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and design instance
    // ****************************************************************
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic slow_osc = 1'b0;
    logic fast_osc = 1'b0;
    logic rc_opt = 1'b1;
    pwr_clk_pkg::ctrl_t ctrl;
    logic logic_supply_high;
    logic cpu_clock;
    logic [31:0] q;
    logic err;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int i;
    logic [7:0] steps [9] = '{8'h80, 8'h82, 8'h83, 8'h82, 8'h80, 8'h08, 8'h18, 8'h38, 8'h08};

    power_clock_mode_control i_power_clock_mode_control (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slow_oscillator(slow_osc), .fast_oscillator(fast_osc),
        .rc_slow_osc_option(rc_opt), .ctrl(ctrl), .logic_supply_high(logic_supply_high),
        .cpu_clock(cpu_clock)
    );

    // Clock, oscillators and a cycle limit well above the run of about 200 cycles
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        fast_osc <= cyc[1];
        slow_osc <= cyc[3];
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Registered outputs are settled by the falling edge
        @(negedge clk);
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk("ctrl reset", {24'h0, ctrl}, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl read reset", q, 32'h0);
        // Fast clock bring-up, return, then booster entry, both boost modes, and back to booster only
        for (i = 0; i < 9; i++) begin
            apb(1'b1, 8'h00, {24'h0, steps[i]});
            chk("ctrl out", {24'h0, ctrl}, {24'h0, steps[i]});
            if (steps[i] == 8'h83) begin
                repeat (40) apb(1'b0, 8'h04, 32'h0);
                chk("active fast", {31'h0, q[0]}, 32'h1);
            end
        end
        apb(1'b0, 8'h04, 32'h0);
        chk("active slow", {31'h0, q[0]}, 32'h0);
        // RC strap holds logic supply high whenever the fast oscillator runs
        apb(1'b1, 8'h00, 32'h2);
        chk("supply held", {31'h0, logic_supply_high}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("strap seen", {31'h0, q[2]}, 32'h1);
        chk("status supply", {31'h0, q[1]}, 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        chk("supply low", {31'h0, logic_supply_high}, 32'h0);
        // Status is read only, unmapped space errors
        apb(1'b1, 8'h04, 32'hff);
        chk("status write", {24'h0, ctrl}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", q, 32'h0);
        // Second reset in mid-run with every control set
        apb(1'b1, 8'h00, 32'hff);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("ctrl rereset", {24'h0, ctrl}, 32'h0);
        chk("supply rereset", {31'h0, logic_supply_high}, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk("strap again", {31'h0, q[2]}, 32'h1);
        wrap_up();
    end
endmodule

`default_nettype wire
